// >>> verilog/acsreg_bank.sv
// Purpose: access services control, egress vector, multicast cap header
// Assumes: straps are asynchronous pins and are synchronised here
// Notes: read data stand one cycle after the read strobe
//
// Overview of operation
// R1: control bit 0 enables source validation
// R2: control bit 1 enables translation blocking
// R3: control bit 2 enables request redirect
// R4: control bit 3 enables completion redirect
// R5: control bit 4 enables upstream forwarding
// R6: control bit 5 enables egress control
// R7: control bit 6 enables direct translated control
// R8: downstream enables writable, upstream read-only, reset zero
// R9: control bits 15 to 7 read zero
// R10: vector bit per port, resets zero
// R11: set vector bit blocks requests to that port
// R12: vector ignored unless egress control enabled
// R13: own port vector bit reads zero
// R14: merged even port: own and next bit zero
// R15: header bits 15:0 read identifier 0x12
// R16: header bits 19:16 read version 0x1
// R17: header bits 31:20 lockable next pointer
// R18: vector size 0x10 reported on downstream
// R19: writes to read-only bits are ignored
`timescale 1ns/1ps
module acsreg_bank
    import acsreg_pkg::*;
#(
    parameter logic [MC_NEXT_PTR_W-1:0] NEXT_PTR_DEFAULT = 12'h000
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [ACSREG_ADDR_W-1:0] addr_i,
    input wire logic [ACSREG_DATA_W-1:0] wdata_i,
    input wire logic write_i,
    input wire logic read_i,
    output logic [ACSREG_DATA_W-1:0] rdata_o,
    input wire logic port_downstream_i,
    input wire logic merged_mode_i,
    input wire logic [ACSREG_PORT_W-1:0] port_number_i,
    input wire logic cap_unlock_i,
    input wire acsreg_egress_req_t egress_req_i,
    output logic egress_block_o,
    output acsreg_enables_t enables_o,
    output logic [ACSREG_PORTS-1:0] egress_vector_o,
    output logic [7:0] egress_vector_size_o
);
    // writable bits of the vector for a given port and mode
    function automatic logic [ACSREG_PORTS-1:0] vector_mask(
        input logic [ACSREG_PORT_W-1:0] port,
        input logic merged
    );
        logic [ACSREG_PORTS-1:0] m;
        m = ~(16'h0001 << port); // R13
        if (merged && !port[0]) begin
            m = m & ~(16'h0002 << port); // R14
        end
        return m;
    endfunction

    function automatic logic [ACSREG_ADDR_W-1:0] byte_addr(
        input logic [ACSREG_ADDR_W-1:0] idx
    );
        return ACSREG_ADDR_W'(idx << ACSREG_BYTE_SHIFT);
    endfunction

    // two-flop synchronisers for the straps
    logic [ACSREG_PORT_W+2:0] strap_meta;
    logic [ACSREG_PORT_W+2:0] strap_sync;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            strap_meta <= '0;
            strap_sync <= '0;
        end else begin
            strap_meta <= {cap_unlock_i, merged_mode_i, port_downstream_i,
                           port_number_i};
            strap_sync <= strap_meta;
        end
    end

    wire logic [ACSREG_PORT_W-1:0] port_num = strap_sync[ACSREG_PORT_W-1:0];
    wire logic is_down = strap_sync[ACSREG_PORT_W];
    wire logic merged = strap_sync[ACSREG_PORT_W+1];
    wire logic unlocked = strap_sync[ACSREG_PORT_W+2];

    wire logic hit_ctl = addr_i == byte_addr(IDX_ACCESS_SERVICES_CONTROL);
    wire logic hit_vec = addr_i == byte_addr(IDX_PEER_EGRESS_BLOCK_VECTOR);
    wire logic hit_hdr = addr_i == byte_addr(IDX_MULTICAST_CAP_HEADER);
    wire logic [ACSREG_PORTS-1:0] vec_mask = vector_mask(port_num, merged);

    acsreg_enables_t access_services_control;
    logic [ACSREG_PORTS-1:0] peer_egress_block_vector;
    logic [MC_NEXT_PTR_W-1:0] next_capability_pointer;

    // upstream enables never take a write
    wire logic ctl_we = write_i && hit_ctl && is_down; // R8 R19
    wire logic vec_we = write_i && hit_vec;
    wire logic hdr_we = write_i && hit_hdr && unlocked; // R17 R19

    wire acsreg_enables_t next_ctl = acsreg_enables_t'(
        wdata_i[CTL_ENABLE_W-1:0]);
    wire logic [ACSREG_PORTS-1:0] next_vec =
        wdata_i[ACSREG_PORTS-1:0] & vec_mask; // R13 R14 R19

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            access_services_control <= acsreg_enables_t'(
                CTL_RESET[CTL_ENABLE_W-1:0]); // R8
            peer_egress_block_vector <= EGRESS_VECTOR_RESET; // R10
            next_capability_pointer <= NEXT_PTR_DEFAULT;
        end else begin
            if (ctl_we) begin
                access_services_control <= next_ctl; // R8
            end
            if (vec_we) begin
                peer_egress_block_vector <= next_vec; // R10
            end
            if (hdr_we) begin
                next_capability_pointer <=
                    wdata_i[MC_NEXT_PTR_LSB +: MC_NEXT_PTR_W]; // R17
            end
        end
    end

    // an upstream port presents its enables as zero
    wire acsreg_enables_t eff_enables = is_down ?
        access_services_control : acsreg_enables_t'('0); // R8
    wire logic [ACSREG_PORTS-1:0] eff_vector =
        peer_egress_block_vector & vec_mask; // R13 R14

    wire logic [15:0] ctl_read = {9'h000, eff_enables}; // R9
    wire logic [31:0] hdr_read = {next_capability_pointer, // R17
        MC_CAPABILITY_VERSION, // R16
        MC_CAPABILITY_IDENTIFIER}; // R15
    wire logic [ACSREG_DATA_W-1:0] read_mux =
        hit_ctl ? {16'h0000, ctl_read} :
        hit_vec ? {16'h0000, eff_vector} :
        hit_hdr ? hdr_read : 32'h00000000;

    // egress decision for one request, used only with the enable set
    wire logic next_block = egress_req_i.valid && eff_enables.egress && // R12
        eff_vector[egress_req_i.target]; // R11

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= 32'h00000000;
            egress_block_o <= 1'b0;
            enables_o <= acsreg_enables_t'('0);
            egress_vector_o <= 16'h0000;
            egress_vector_size_o <= EGRESS_VECTOR_SIZE_UP;
        end else begin
            rdata_o <= read_i ? read_mux : 32'h00000000;
            egress_block_o <= next_block; // R6 R11
            enables_o <= eff_enables; // R1 R2 R3 R4 R5 R6 R7
            egress_vector_o <= eff_enables.egress ?
                eff_vector : 16'h0000; // R12
            egress_vector_size_o <= is_down ?
                EGRESS_VECTOR_SIZE_DOWN : EGRESS_VECTOR_SIZE_UP; // R18
        end
    end
endmodule // acsreg_bank

// >>> verilog/acsreg_pkg.sv
// Purpose: constants and types of the access services register bank
// Assumes: register index times four gives the byte address
// Notes: widths fixed, no parameters shorten any count
package acsreg_pkg;
    localparam int ACSREG_ADDR_W = 12;
    localparam int ACSREG_DATA_W = 32;
    localparam int ACSREG_PORT_W = 4;
    localparam int ACSREG_PORTS = 16;

    // register indexes; the byte address is the index times four
    localparam logic [ACSREG_ADDR_W-1:0] IDX_ACCESS_SERVICES_CONTROL = 12'h326;
    localparam logic [ACSREG_ADDR_W-1:0] IDX_PEER_EGRESS_BLOCK_VECTOR = 12'h328;
    localparam logic [ACSREG_ADDR_W-1:0] IDX_MULTICAST_CAP_HEADER = 12'h330;
    localparam int ACSREG_BYTE_SHIFT = 2;

    // control register layout
    localparam int CTL_SOURCE_VALID_BIT = 0;
    localparam int CTL_XLATE_BLOCK_BIT = 1;
    localparam int CTL_REQ_REDIRECT_BIT = 2;
    localparam int CTL_CPL_REDIRECT_BIT = 3;
    localparam int CTL_UP_FORWARD_BIT = 4;
    localparam int CTL_EGRESS_BIT = 5;
    localparam int CTL_DIRECT_XLATE_BIT = 6;
    localparam int CTL_ENABLE_W = 7;
    localparam logic [15:0] CTL_RESET = 16'h0000;
    localparam logic [15:0] EGRESS_VECTOR_RESET = 16'h0000;

    // multicast capability header fields
    localparam logic [15:0] MC_CAPABILITY_IDENTIFIER = 16'h0012;
    localparam logic [3:0] MC_CAPABILITY_VERSION = 4'h1;
    localparam int MC_NEXT_PTR_LSB = 20;
    localparam int MC_NEXT_PTR_W = 12;

    // egress vector size reported by a downstream and by an upstream port
    localparam logic [7:0] EGRESS_VECTOR_SIZE_DOWN = 8'h10;
    localparam logic [7:0] EGRESS_VECTOR_SIZE_UP = 8'h00;

    typedef struct packed {
        logic direct_xlate;
        logic egress;
        logic up_forward;
        logic cpl_redirect;
        logic req_redirect;
        logic xlate_block;
        logic source_valid;
    } acsreg_enables_t;

    typedef struct packed {
        logic valid;
        logic [ACSREG_PORT_W-1:0] target;
    } acsreg_egress_req_t;
endpackage

// >>> tb/acsreg_bank_assertions.sv
// Purpose: port checks of the access services register bank
// Assumes: straps held steady while their checks run
// Notes: bound into every acsreg_bank
`timescale 1ns/1ps
module acsreg_bank_assertions
    import acsreg_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [ACSREG_ADDR_W-1:0] addr_i,
    input wire logic [ACSREG_DATA_W-1:0] wdata_i,
    input wire logic write_i,
    input wire logic read_i,
    input wire logic [ACSREG_DATA_W-1:0] rdata_o,
    input wire logic port_downstream_i,
    input wire logic merged_mode_i,
    input wire logic [ACSREG_PORT_W-1:0] port_number_i,
    input wire logic cap_unlock_i,
    input wire acsreg_egress_req_t egress_req_i,
    input wire logic egress_block_o,
    input wire acsreg_enables_t enables_o,
    input wire logic [ACSREG_PORTS-1:0] egress_vector_o,
    input wire logic [7:0] egress_vector_size_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    a_rdata_idle: assert property (!$past(read_i)
        |-> rdata_o == 32'h0) else $error("read data outside read");
    a_ctl_reserved: assert property ($past(read_i && addr_i == 12'hC98)
        |-> rdata_o[31:7] == 25'h0) else $error("control reserved bits");
    a_hdr_fixed: assert property ($past(read_i && addr_i == 12'hCC0)
        |-> rdata_o[19:0] == 20'h10012) else $error("header id or version");
    a_block_cause: assert property (egress_block_o
        |-> $past(egress_req_i.valid)) else $error("block without request");
    a_block_hit: assert property ($past(!write_i) && $past(!write_i, 2)
        && $past(egress_req_i.valid && egress_vector_o[egress_req_i.target])
        |-> egress_block_o) else $error("set vector bit not blocking");
    a_vector_gated: assert property (|egress_vector_o
        |-> enables_o.egress) else $error("vector live while disabled");
    a_upstream_zero: assert property ((!port_downstream_i)[*5]
        |-> enables_o == 7'h0) else $error("upstream enables set");
    a_own_bit: assert property (($stable(port_number_i)
        && $stable(merged_mode_i))[*5] |-> !egress_vector_o[port_number_i])
        else $error("own vector bit set");
endmodule // acsreg_bank_assertions

bind acsreg_bank acsreg_bank_assertions acsreg_bank_assertions_inst (.*);

// >>> tb/tb.sv
// Purpose: self-checking bench of the access services register bank
// Assumes: straps are seen two clocks after they change; wt waits four
// Notes: no random stimulus
`timescale 1ns/1ps
module tb;
    import acsreg_pkg::*;
    logic clk_i = 0, reset_n_i = 0, write_i = 0, read_i = 0;
    logic port_downstream_i = 1, merged_mode_i = 0, cap_unlock_i = 0;
    logic [11:0] addr_i = 12'h0;
    logic [31:0] wdata_i = 32'h0, rdata_o;
    logic [3:0] port_number_i = 4'h3;
    acsreg_egress_req_t egress_req_i = '0;
    acsreg_enables_t enables_o;
    logic egress_block_o;
    logic [15:0] egress_vector_o;
    logic [7:0] egress_vector_size_o;
    int bad_count = 0, tests_run = 0;
    acsreg_bank acsreg_bank_inst (.*);
    always #25 clk_i = ~clk_i;
    task chk(input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        write_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        write_i <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk_i);
        read_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        read_i <= 1'b0;
        #1 chk(rdata_o, e);
    endtask
    task req(input logic [3:0] t, input logic e);
        @(posedge clk_i);
        egress_req_i <= {1'b1, t};
        @(posedge clk_i);
        egress_req_i <= '0;
        #1 chk({31'h0, egress_block_o}, {31'h0, e});
    endtask
    task wt;
        repeat (4) @(posedge clk_i);
        #1;
    endtask
    task results;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        bad_count++;
        results;
    end
    initial begin
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        wt;
        rd(12'hC98, 32'h0);
        rd(12'hCA0, 32'h0);
        rd(12'hCC0, 32'h0001_0012);
        chk({24'h0, egress_vector_size_o}, 32'h10);
        for (int i = 0; i < 7; i++) begin
            wr(12'hC98, 32'h1 << i);
            wt;
            chk({25'h0, enables_o}, 32'h1 << i);
        end
        $display("test enables done");
        wr(12'hC98, 32'hFFFF_FFFF);
        rd(12'hC98, 32'h7F);
        wr(12'hCA0, 32'hFFFF_FFFF);
        rd(12'hCA0, 32'hFFF7);
        wr(12'hC98, 32'h40);
        wt;
        chk({16'h0, egress_vector_o}, 32'h0);
        req(4'h5, 1'b0);
        wr(12'hC98, 32'h20);
        wt;
        chk({16'h0, egress_vector_o}, 32'hFFF7);
        req(4'h5, 1'b1);
        req(4'h3, 1'b0);
        $display("test egress done");
        wr(12'hCC0, 32'hFFFF_FFFF);
        rd(12'hCC0, 32'h0001_0012);
        @(posedge clk_i);
        cap_unlock_i <= 1'b1;
        wt;
        wr(12'hCC0, 32'hABCF_FFFF);
        rd(12'hCC0, 32'hABC1_0012);
        @(posedge clk_i);
        merged_mode_i <= 1'b1;
        port_number_i <= 4'h4;
        wt;
        wr(12'hCA0, 32'hFFFF);
        rd(12'hCA0, 32'hFFCF);
        @(posedge clk_i);
        port_downstream_i <= 1'b0;
        wt;
        wr(12'hC98, 32'h7F);
        rd(12'hC98, 32'h0);
        chk({24'h0, egress_vector_size_o}, 32'h0);
        rd(12'hC9C, 32'h0);
        $display("test straps done");
        results;
    end
endmodule // tb
